// ==== core/acl_key_field_builder.v ====
`include "acl_key_regs.vh"
`default_nettype none

module acl_key_field_builder #(
   parameter KEY_W = 192
) (
   input wire clk,
   input wire rst_b,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // frame fields from the parser
   input wire frm_valid,
   input wire [1:0] frm_kind,
   input wire first_lookup,
   input wire [47:0] dmac,
   input wire [47:0] smac,
   input wire [63:0] l2_payload,
   input wire [15:0] arp_hw_type,
   input wire [15:0] arp_proto_type,
   input wire [7:0] arp_hw_len,
   input wire [7:0] arp_proto_len,
   input wire [15:0] resolution_opcode,
   input wire [47:0] arp_sender_hw,
   input wire [47:0] arp_target_hw,
   input wire [31:0] arp_sender_ip,
   input wire [31:0] arp_target_ip,
   input wire is_ipv6,
   input wire more_frags,
   input wire [12:0] frag_offset,
   input wire [3:0] ip_hdr_len,
   input wire [7:0] ip_ttl,
   input wire [7:0] ip_tos,
   input wire [7:0] ip_proto,
   input wire [127:0] ip_src,
   input wire [127:0] ip_dst,
   input wire [15:0] src_port_field,
   input wire [15:0] dest_port_field,
   input wire [31:0] tcp_seq,
   input wire tcp_fin,
   input wire is_ptp,
   input wire [3:0] ptp_msg_type,
   input wire [7:0] ptp_domain,
   input wire [11:0] cls_vid,
   input wire [5:0] cls_dscp,
   // key to the match stage
   output reg key_valid,
   output reg [KEY_W-1:0] key_data,
   output reg [KEY_W-1:0] key_care,
   output reg key_skip
);

   // ********************************
   // range checker
   // ********************************
   function in_range;
      input [15:0] val;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_range = (val >= lo) && (val <= hi);
      end
   endfunction

   function rng_hit;
      input [2:0] kind;
      input [31:0] bound;
      input [15:0] sp;
      input [15:0] dp;
      input [11:0] vid;
      input [5:0] dscp;
      reg [15:0] lo;
      reg [15:0] hi;
      begin
         lo = bound[15:0];
         hi = bound[31:16];
         case (kind)
            `RNG_SPORT: rng_hit = in_range(sp, lo, hi);
            `RNG_DPORT: rng_hit = in_range(dp, lo, hi);
            `RNG_EITHER: rng_hit = in_range(sp, lo, hi) ||
               in_range(dp, lo, hi);
            `RNG_VID: rng_hit = in_range({4'h0, vid}, lo, hi);
            `RNG_DSCP: rng_hit = in_range({10'h000, dscp}, lo, hi);
            default: rng_hit = 1'b0;
         endcase
      end
   endfunction

   // ********************************
   // registers
   // ********************************
   reg ipv6_std_ena;
   reg [23:0] rng_kind;
   reg [31:0] rng_bound [0:`NUM_RNG-1];
   reg [15:0] key_count;
   reg [15:0] skip_count;
   reg [3:0] last_type;
   reg ack;
   reg [31:0] next_prdata;
   reg next_err;
   integer i;
   integer j;

   // ********************************
   // address decode
   // ********************************
   wire setup = psel & ~penable;
   wire wr_done = psel & penable & pready & pwrite;
   wire bound_sel = (paddr[7:5] == 3'h1);
   wire [2:0] bound_idx = paddr[4:2];
   wire addr_ok = bound_sel || (paddr == `REG_CTRL) ||
      (paddr == `REG_STATUS) || (paddr == `REG_RNG_KIND) ||
      (paddr == `REG_SKIPS);

   assign pready = ack;

   // ********************************
   // read mux
   // ********************************
   always @* begin
      next_err = ~addr_ok;
      next_prdata = 32'h0000_0000;
      if (bound_sel) begin
         next_prdata = rng_bound[bound_idx];
      end else begin
         case (paddr)
            `REG_CTRL: next_prdata = {31'h0000_0000, ipv6_std_ena};
            `REG_STATUS: next_prdata = {12'h000, last_type, key_count};
            `REG_RNG_KIND: next_prdata = {8'h00, rng_kind};
            `REG_SKIPS: next_prdata = {16'h0000, skip_count};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // ********************************
   // bus handshake
   // ********************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         ack <= setup;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_err;
         end
      end
   end

   // ********************************
   // register writes
   // ********************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ipv6_std_ena <= 1'b0;
         rng_kind <= `RNG_KIND_RESET;
         for (i = 0; i < `NUM_RNG; i = i + 1) begin
            rng_bound[i] <= `RNG_BOUND_RESET;
         end
      end else if (wr_done) begin
         if (bound_sel) begin
            rng_bound[bound_idx] <= pwdata;
         end else if (paddr == `REG_CTRL) begin
            ipv6_std_ena <= pwdata[0];
         end else if (paddr == `REG_RNG_KIND) begin
            rng_kind <= pwdata[23:0];
         end
      end
   end

   // ********************************
   // key assembly
   // ********************************
   reg [KEY_W-1:0] next_data;
   reg [KEY_W-1:0] next_care;
   reg [3:0] next_type;
   reg next_skip;
   reg [7:0] rng_mask;
   reg no_l4;
   reg addr_eq;
   wire is_snap = (l2_payload[63:40] == `LLC_SNAP_HDR);

   // ********************************
   // key type and skip
   // ********************************
   always @* begin
      next_type = `KT_LLC;
      next_skip = 1'b0;
      case (frm_kind)
         `FK_L2: next_type = is_snap ? `KT_SNAP : `KT_LLC;
         `FK_ARP: next_type = `KT_ARP;
         `FK_IP: begin
            next_type = `KT_IP4;
            next_skip = is_ipv6 & ipv6_std_ena;
         end
         default: begin
            next_skip = 1'b1;
         end
      endcase
   end

   // ********************************
   // range mask
   // ********************************
   always @* begin
      rng_mask = 8'h00;
      for (j = 0; j < `NUM_RNG; j = j + 1) begin
         rng_mask[j] = rng_hit(rng_kind[3*j +: 3], rng_bound[j],
            src_port_field, dest_port_field, cls_vid, cls_dscp);
      end
   end

   // ********************************
   // key fields
   // ********************************
   always @* begin
      next_data = {KEY_W{1'b0}};
      next_care = {KEY_W{1'b0}};
      no_l4 = 1'b0;
      addr_eq = 1'b0;
      case (frm_kind)
         `FK_L2: begin
            next_data[`B_DMAC +: 48] = dmac;
            next_data[`B_SMAC +: 48] = smac;
            next_care[`B_DMAC +: 96] = {96{1'b1}};
            if (is_snap) begin
               next_data[`B_L2DATA +: 40] = l2_payload[39:0];
            end else begin
               next_data[`B_L2DATA +: 40] = l2_payload[63:24];
            end
            next_care[`B_L2DATA +: 40] = {40{1'b1}};
         end
         `FK_ARP: begin
            next_data[`B_ARP_SMAC +: 48] = smac;
            next_data[`B_HW_OK] = (arp_hw_type == `ARP_HW_ETH);
            next_data[`B_PROTO_OK] = (arp_proto_type == `ARP_PROTO_IP);
            next_data[`B_LEN_OK] = (arp_hw_len == `ARP_HW_LEN) &&
               (arp_proto_len == `ARP_PROTO_LEN);
            next_data[`B_TGT_MATCH] = (arp_target_hw == smac);
            next_data[`B_SND_MATCH] = (arp_sender_hw == smac);
            case (resolution_opcode)
               16'h0001: next_data[`B_OPCODE +: 2] = 2'h0;
               16'h0002: next_data[`B_OPCODE +: 2] = 2'h1;
               16'h0003: next_data[`B_OPCODE +: 2] = 2'h2;
               16'h0004: next_data[`B_OPCODE +: 2] = 2'h3;
               default: next_data[`B_OP_UNK] = 1'b1;
            endcase
            next_data[`B_ARP_TIP +: 32] = arp_target_ip;
            next_data[`B_ARP_SIP +: 32] = arp_sender_ip;
            next_data[`B_ARP_EQ] = (arp_sender_ip == arp_target_ip);
            next_care[`B_ARP_SMAC +: 121] = {121{1'b1}};
         end
         `FK_IP: begin
            next_data[`B_IP4] = ~is_ipv6;
            next_data[`B_FRAG] = ~is_ipv6 &
               (more_frags | (frag_offset != 13'h0000));
            next_data[`B_FRAG_OFS] = ~is_ipv6 &
               (frag_offset != 13'h0000);
            next_data[`B_OPTS] = ~is_ipv6 &
               (ip_hdr_len > `IP_BASE_IHL);
            next_data[`B_TTL] = (ip_ttl != 8'h00);
            next_data[`B_TOS +: 8] = ip_tos;
            if (is_ipv6) begin
               next_data[`B_DIP +: 32] = ip_src[63:32];
               next_data[`B_SIP +: 32] = ip_src[31:0];
               addr_eq = (ip_src == ip_dst);
            end else begin
               next_data[`B_DIP +: 32] = ip_dst[31:0];
               next_data[`B_SIP +: 32] = ip_src[31:0];
               addr_eq = (ip_src[31:0] == ip_dst[31:0]);
            end
            next_data[`B_IP_EQ] = addr_eq;
            next_data[`B_TCP] = (ip_proto == `IP_PROTO_TCP);
            next_care[`B_IP4 +: 79] = {79{1'b1}};
            no_l4 = next_data[`B_FRAG_OFS] | next_data[`B_OPTS];
            next_data[`B_DPORT +: 16] = dest_port_field;
            next_data[`B_SPORT +: 16] = src_port_field;
            next_data[`B_RNG +: 8] = rng_mask;
            next_data[`B_PORT_EQ] = (src_port_field == dest_port_field);
            if (is_ptp) begin
               next_data[`B_SEQ0] = ptp_msg_type[0];
               next_data[`B_FIN] = ptp_msg_type[1];
               next_data[`B_PTP_DOM +: 8] = ptp_domain;
            end else begin
               next_data[`B_SEQ0] = (tcp_seq == 32'h0000_0000);
               next_data[`B_FIN] = tcp_fin;
            end
            next_care[`B_DPORT +: 56] = {56{1'b1}};
            if (no_l4) begin
               next_data[`B_DPORT +: 56] = {56{1'b0}};
               next_care[`B_DPORT +: 56] = {56{1'b0}};
            end
         end
         default: no_l4 = 1'b0;
      endcase
      next_data[`B_TYPE +: 4] = next_type;
      next_data[`B_FIRST] = first_lookup;
      next_care[`B_TYPE +: 5] = 5'h1F;
   end

   // ********************************
   // output stage
   // ********************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         key_valid <= 1'b0;
         key_skip <= 1'b0;
         key_data <= {KEY_W{1'b0}};
         key_care <= {KEY_W{1'b0}};
      end else begin
         key_valid <= frm_valid & ~next_skip;
         key_skip <= frm_valid & next_skip;
         if (frm_valid & ~next_skip) begin
            key_data <= next_data;
            key_care <= next_care;
         end
      end
   end

   // ********************************
   // status counters
   // ********************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         key_count <= 16'h0000;
         skip_count <= 16'h0000;
         last_type <= 4'h0;
      end else begin
         if (frm_valid & ~next_skip) begin
            key_count <= key_count + 16'h0001;
            last_type <= next_type;
         end
         if (frm_valid & next_skip) begin
            skip_count <= skip_count + 16'h0001;
         end
      end
   end

endmodule

`default_nettype wire

// ==== core/acl_key_regs.vh ====
// What this block does
// - llc and snap keys: dest mac at bit 46, src mac at 94
// - llc key: 40-bit llc header and data at bit 142
// - snap key: 40-bit snap header after llc AA-AA-03, at bit 142
// - arp key: src mac at 46; bit 94 set for ethernet hardware type
// - arp key: bit 95 set when protocol space is ip
// - arp key: bit 96 set only for lengths 6 and 4
// - arp key: bit 97 target hw equals smac, bit 98 sender hw
// - arp key: 2-bit opcode at 100, unknown opcode flag at 99
// - arp key: target ip at 102, sender ip at 134
// - arp key: bit 166 set when sender ip equals target ip
// - ip key: ipv4 flag at 46; ipv6 uses it when standard entry off
// - ip key: fragmented flag at 47 on more-fragments or offset
// - ip key: bit 48 for nonzero offset; layer-4 fields don't-care
// - ip key: options flag at 49 when ihl above 5; layer-4 don't-care
// - ip key: ttl nonzero flag at 50, tos byte at 51
// - ip key: address words at 59 and 91, ipv6 source low half
// - ip key: address equality at 123, full 128 bits for ipv6
// - ip key: tcp flag at 124 when protocol is 6
// - ip key: dest port at 125, source port at 141
// - ip key: 8-bit range mask at 157, frame ports, classified vid/dscp
// - ip key: port equality flag at 165
// - ip key: bits 166/167 seq zero and fin, or ptp message type bits
// - 4-bit key type at bit 0: 1 llc, 2 snap, 3 arp, 4 ip
// - bit 4 set for first lookup, cleared for second
// - ip key: ptp domain number at bit 173
`ifndef ACL_KEY_REGS_VH
`define ACL_KEY_REGS_VH

// ********************************
// register offsets
// ********************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RNG_KIND 8'h08
`define REG_SKIPS 8'h0C
`define REG_RNG_BOUND 8'h20
`define CTRL_RESET 32'h0000_0000
`define RNG_KIND_RESET 24'h00_0000
`define RNG_BOUND_RESET 32'hFFFF_0000

// ********************************
// key types and range kinds
// ********************************
`define KT_LLC 4'h1
`define KT_SNAP 4'h2
`define KT_ARP 4'h3
`define KT_IP4 4'h4
`define FK_L2 2'h0
`define FK_ARP 2'h1
`define FK_IP 2'h2
`define RNG_NONE 3'h0
`define RNG_SPORT 3'h1
`define RNG_DPORT 3'h2
`define RNG_EITHER 3'h3
`define RNG_VID 3'h4
`define RNG_DSCP 3'h5
`define NUM_RNG 8

// ********************************
// protocol values
// ********************************
`define LLC_SNAP_HDR 24'hAA_AA03
`define ARP_HW_ETH 16'h0001
`define ARP_PROTO_IP 16'h0800
`define ARP_HW_LEN 8'h06
`define ARP_PROTO_LEN 8'h04
`define IP_PROTO_TCP 8'h06
`define IP_BASE_IHL 4'h5

// ********************************
// field positions
// ********************************
`define B_TYPE 0
`define B_FIRST 4
`define B_DMAC 46
`define B_SMAC 94
`define B_L2DATA 142
`define B_ARP_SMAC 46
`define B_HW_OK 94
`define B_PROTO_OK 95
`define B_LEN_OK 96
`define B_TGT_MATCH 97
`define B_SND_MATCH 98
`define B_OP_UNK 99
`define B_OPCODE 100
`define B_ARP_TIP 102
`define B_ARP_SIP 134
`define B_ARP_EQ 166
`define B_IP4 46
`define B_FRAG 47
`define B_FRAG_OFS 48
`define B_OPTS 49
`define B_TTL 50
`define B_TOS 51
`define B_DIP 59
`define B_SIP 91
`define B_IP_EQ 123
`define B_TCP 124
`define B_DPORT 125
`define B_SPORT 141
`define B_RNG 157
`define B_PORT_EQ 165
`define B_SEQ0 166
`define B_FIN 167
`define B_PTP_DOM 173
`define B_L4_LAST 180

`endif

// ==== tb/acl_key_field_builder_assertions.sv ====
`default_nettype none
module acl_key_field_builder_assertions #(
   parameter KEY_W = 192
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frm_valid,
   input wire logic [1:0] frm_kind,
   input wire logic is_ipv6,
   input wire logic first_lookup,
   input wire logic [47:0] dmac,
   input wire logic [47:0] smac,
   input wire logic [7:0] ip_proto,
   input wire logic [12:0] frag_offset,
   input wire logic [3:0] ip_hdr_len,
   input wire logic key_valid,
   input wire logic key_skip,
   input wire logic [KEY_W-1:0] key_data,
   input wire logic [KEY_W-1:0] key_care
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************************
   // key and bus checks
   // ********************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   wire logic key_in = frm_valid && frm_kind != 2'h3 && !is_ipv6;
   wire logic ip4_in = frm_valid && frm_kind == 2'h2 && !is_ipv6;
   wire logic l4_off = frag_offset != 13'h0 || ip_hdr_len > 4'h5;
   property p_ready;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing wrong");
   property p_err;
      pready && paddr >= 8'h40 |-> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("no error on unmapped");
   property p_key;
      key_in |=> key_valid && !key_skip;
   endproperty
   a_key: assert property (p_key) else $error("key strobe missing");
   property p_skip;
      frm_valid && frm_kind == 2'h3 |=> key_skip && !key_valid;
   endproperty
   a_skip: assert property (p_skip) else $error("skip strobe missing");
   property p_idle;
      !frm_valid |=> !key_valid && !key_skip;
   endproperty
   a_idle: assert property (p_idle) else $error("spurious key strobe");
   property p_first;
      key_in |=> key_data[4] == $past(first_lookup) && &key_care[4:0];
   endproperty
   a_first: assert property (p_first) else $error("first bit wrong");
   property p_macs;
      frm_valid && frm_kind == 2'h0 |=>
         key_data[93:46] == $past(dmac) && key_data[141:94] == $past(smac);
   endproperty
   a_macs: assert property (p_macs) else $error("mac fields wrong");
   property p_tcp;
      ip4_in |=> key_data[124] == ($past(ip_proto) == 8'h06);
   endproperty
   a_tcp: assert property (p_tcp) else $error("tcp flag wrong");
   property p_l4dc;
      ip4_in && l4_off |=> key_care[164:125] == 40'h0;
   endproperty
   a_l4dc: assert property (p_l4dc) else $error("l4 cared");
   c_l4off: cover property (ip4_in && l4_off);
   c_skip: cover property (key_skip);
   c_err: cover property (pready && pslverr);
endmodule

bind acl_key_field_builder acl_key_field_builder_assertions #(
   .KEY_W(KEY_W)
) i_chk (.*);
`default_nettype wire

// ==== tb/acl_key_match_model.sv ====
`default_nettype none
module acl_key_match_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic key_valid,
   input wire logic [191:0] key_data,
   input wire logic [191:0] key_care,
   output logic [191:0] got_data,
   output logic [191:0] got_care,
   output logic [15:0] n_keys
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************************
   // match stage: latches each key
   // ********************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         got_data <= '0;
         got_care <= '0;
         n_keys <= '0;
      end else if (key_valid) begin
         got_data <= key_data;
         got_care <= key_care;
         n_keys <= n_keys + 16'h1;
      end
   end
endmodule
`default_nettype wire

// ==== tb/acl_key_field_builder_tb.sv ====
`include "acl_key_regs.vh"
`default_nettype none
module acl_key_field_builder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic frm_valid = 0, first_lookup = 0, is_ipv6 = 0, more_frags = 0;
   logic tcp_fin = 0, is_ptp = 0, pready, pslverr, key_valid, key_skip;
   logic [1:0] frm_kind = '0;
   logic [3:0] ip_hdr_len = 4'h5, ptp_msg_type = '0;
   logic [5:0] cls_dscp = '0;
   logic [7:0] paddr = '0, arp_hw_len = '0, arp_proto_len = '0;
   logic [7:0] ip_ttl = '0, ip_tos = '0, ip_proto = '0, ptp_domain = '0;
   logic [11:0] cls_vid = '0;
   logic [12:0] frag_offset = '0;
   logic [15:0] arp_hw_type = '0, arp_proto_type = '0, resolution_opcode = '0;
   logic [15:0] src_port_field = '0, dest_port_field = '0, n_keys;
   logic [31:0] pwdata = '0, arp_sender_ip = '0, arp_target_ip = '0;
   logic [31:0] tcp_seq = '0, prdata;
   logic [47:0] dmac = '0, smac = '0, arp_sender_hw = '0, arp_target_hw = '0;
   logic [63:0] l2_payload = '0;
   logic [127:0] ip_src = '0, ip_dst = '0;
   logic [191:0] key_data, key_care, got_data, got_care, k;
   logic l4off;
   int n_fail = 0, check_count = 0, cycles = 0;

   acl_key_field_builder i_dut (.*);
   acl_key_match_model i_match (.*);

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         results();
      end
   end

   // ********************************
   // tasks
   // ********************************
   task automatic results();
      if (n_fail == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [191:0] e, g);
      check_count++;
      if (e !== g) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic er);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      apb(1, a, d, r, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x,
         input logic xe);
      logic [31:0] r;
      logic er;
      apb(0, a, '0, r, er);
      chk("prdata", x, r);
      chk("pslverr", xe, er);
   endtask
   task automatic frame(input logic [1:0] kd);
      frm_valid <= 1;
      frm_kind <= kd;
      @(posedge clk);
      frm_valid <= 0;
      repeat (2) @(posedge clk);
   endtask

   // ********************************
   // main sequence
   // ********************************
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      rdc(`REG_CTRL, `CTRL_RESET, 0);
      rdc(8'h24, `RNG_BOUND_RESET, 0);
      rdc(8'h40, 32'h0, 1);
      wr(`REG_RNG_KIND, 32'h0000_570A);
      wr(8'h20, 32'h0050_0050);
      wr(8'h24, 32'h04D2_04D2);
      wr(8'h28, 32'h0020_0010);
      wr(8'h2C, 32'hFFFF_0051);
      wr(8'h30, 32'h0005_0000);
      rdc(`REG_RNG_KIND, 32'h0000_570A, 0);
      dmac <= 48'h0102_0304_0506;
      smac <= 48'hA1A2_A3A4_A5A6;
      l2_payload <= 64'hAAAA_0411_2233_4455;
      first_lookup <= 1;
      frame(2'h0);
      k = '0;
      k[4:0] = {1'b1, `KT_LLC};
      k[181:46] = {l2_payload[63:24], smac, dmac};
      chk("llc key", k, got_data);
      l2_payload <= 64'hAAAA_0300_0000_0806;
      first_lookup <= 0;
      frame(2'h0);
      k[4:0] = {1'b0, `KT_SNAP};
      k[181:142] = l2_payload[39:0];
      chk("snap key", k, got_data);
      for (int i = 0; i < 6; i++) begin
         resolution_opcode <= 16'(i);
         arp_hw_type <= (i == 2) ? 16'h0006 : `ARP_HW_ETH;
         arp_proto_type <= (i == 3) ? 16'h86DD : `ARP_PROTO_IP;
         arp_hw_len <= 8'h06;
         arp_proto_len <= (i == 4) ? 8'h10 : 8'h04;
         arp_sender_hw <= i[0] ? smac : dmac;
         arp_target_hw <= i[0] ? dmac : smac;
         arp_sender_ip <= 32'hC0A8_0001;
         arp_target_ip <= (i < 3) ? 32'hC0A8_0001 : 32'hC0A8_0101;
         frame(2'h1);
         k = '0;
         k[4:0] = {1'b0, `KT_ARP};
         k[93:46] = smac;
         k[98:94] = {i[0], !i[0], i != 4, i != 3, i != 2};
         k[101:99] = (i >= 1 && i <= 4) ? {2'(i - 1), 1'b0} : 3'h1;
         k[166:102] = {i < 3, arp_sender_ip, arp_target_ip};
         chk("arp key", k, got_data);
      end
      ip_src <= 128'h0A00_0001;
      for (int j = 0; j < 4; j++) begin
         more_frags <= (j == 0);
         frag_offset <= (j == 2) ? 13'h1 : 13'h0;
         ip_hdr_len <= (j == 3) ? 4'h6 : 4'h5;
         ip_ttl <= 8'(j);
         ip_tos <= 8'h5A;
         ip_proto <= (j == 1) ? 8'h11 : 8'h06;
         ip_dst <= (j == 1) ? 128'h0A00_0001 : 128'h0A00_0002;
         src_port_field <= (j == 0) ? 16'h04D3 : 16'h04D2;
         dest_port_field <= (j == 1) ? 16'h04D2 : 16'h0050;
         tcp_seq <= (j == 0) ? 32'h0 : 32'h5;
         tcp_fin <= (j != 0);
         is_ptp <= (j == 1);
         ptp_msg_type <= 4'hE;
         ptp_domain <= 8'h2C;
         cls_vid <= (j == 0) ? 12'h030 : 12'h020;
         cls_dscp <= (j == 1) ? 6'h05 : 6'h06;
         frame(2'h2);
         l4off = frag_offset != 0 || ip_hdr_len > 4'h5;
         k = '0;
         k[4:0] = {1'b0, `KT_IP4};
         k[58:46] = {ip_tos, ip_ttl != 0, ip_hdr_len > 4'h5,
            frag_offset != 0, more_frags || frag_offset != 0, 1'b1};
         k[124:59] = {ip_proto == 8'h06, ip_src == ip_dst, ip_src[31:0],
            ip_dst[31:0]};
         if (!l4off) begin
            k[167:125] = {is_ptp ? ptp_msg_type[1:0] : {tcp_fin,
               tcp_seq == 0}, src_port_field == dest_port_field, 3'h0,
               (cls_dscp <= 6'h05), 1'b1,
               (cls_vid >= 12'h010 && cls_vid <= 12'h020),
               src_port_field == 16'h04D2, dest_port_field == 16'h0050, src_port_field, dest_port_field};
            if (is_ptp) k[180:173] = ptp_domain;
         end
         chk("ip key", k, got_data);
         chk("l4 care", {43{!l4off}}, got_care[167:125]);
      end
      chk("ptp domain", 8'h0, got_data[180:173]);
      wr(`REG_CTRL, 32'h1);
      is_ipv6 <= 1;
      frame(2'h2);
      frame(2'h3);
      rdc(`REG_SKIPS, 32'h2, 0);
      wr(`REG_CTRL, 32'h0);
      ip_src <= 128'h2001_0DB8_0000_0000_1111_2222_3333_4444;
      ip_dst <= 128'h2002_0DB8_0000_0000_1111_2222_3333_4444;
      frame(2'h2);
      chk("ipv6 key", {1'b0, ip_src[31:0], ip_src[63:32], 1'b0},
         {got_data[123:59], got_data[46]});
      rdc(`REG_STATUS, 32'h0004_000D, 0);
      chk("key count", 16'h000D, n_keys);
      results();
   end
endmodule
`default_nettype wire
